/* adcc_top.sv */
// How it works
// - A start bit high-then-low pulse begins one conversion.
// - Writing start high resets the converter and sets busy.
// - Busy reads one during conversion; hardware clears it at the end.
// - Conversion end raises a one-cycle interrupt request pulse.
// - Alignment zero: high byte bits 11..4, low nibble-up bits 3..0.
// - Alignment one: high byte low nibble bits 11..8, low byte 7..0.
// - Reference code 01 picks external pin; others pick analog supply.
// - Clock select divides system clock by 1 to 128.
// - Power enable must be one for conversions; clear to save power.
// - Four-bit source select routes exactly one input to the converter while power enable is one; none when it is zero.
// - Selected pin loses its pull-high resistor while power enable is one.
// - Configuration bits 7 to 5 always read zero.
// - Conversion lasts 4 sampling plus 12 converting clock cycles.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module adcc_top
  import adcc_pkg::*;
#(
  parameter int NUM_SOURCES = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic compare_in,
  output logic [11:0] dac_trial,
  output logic sample_hold,
  output logic converter_power_enable,
  output logic converter_reset,
  output logic external_reference_sel,
  output logic [NUM_SOURCES-1:0] source_route,
  output logic [NUM_SOURCES-1:0] pin_pullup_disable,
  output logic conv_done_irq
);
  logic [7:0] control_reg;
  logic [7:0] config_reg;
  logic [7:0] result_low_byte_reg;
  logic [7:0] result_high_byte_reg;
  logic busy_reg;
  logic start_prev_reg;
  adcc_state_type state_reg;
  logic [4:0] phase_count_reg;
  adcc_cfg_type cfg;
  logic tick;
  logic [11:0] trial;
  logic [11:0] sar_result;
  logic sar_clear;
  logic start_bit;
  logic start_rise;
  logic start_fall;
  logic conv_end;
  logic [31:0] aw_addr_reg;
  logic aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_have_reg;
  logic do_write;
  logic ctrl_write;
  logic [7:0] config_merged;

  function automatic logic [7:0] wmerge(input logic [7:0] old, input logic [7:0] val,
                                        input logic en);
    wmerge = en ? val : old;
  endfunction

  assign start_bit = control_reg[ADCC_BIT_START];
  assign cfg = '{power: control_reg[ADCC_BIT_POWER], align: control_reg[ADCC_BIT_ALIGN],
                 source: control_reg[ADCC_SRC_LSB +: 4], reference: config_reg[ADCC_REF_LSB +: 2],
                 divider: config_reg[ADCC_DIV_LSB +: 3]};

  // AXI write: address and data captured independently, response after both
  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign ctrl_write = do_write && aw_addr_reg[3:0] == ADCC_OFF_CONTROL
                      && aw_addr_reg[31:4] == 28'h0000000 && w_strb_reg[0];
  assign config_merged = wmerge(config_reg, w_data_reg[7:0], w_strb_reg[0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 32'h00000000;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_have_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_reg && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ADCC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_reg[31:4] == 28'h0000000 && aw_addr_reg[1:0] == 2'h0)
                     ? ADCC_RESP_OKAY : ADCC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register: busy is hardware-owned, never taken from the bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_reg <= ADCC_CONTROL_RESET;
      config_reg <= ADCC_CONFIG_RESET;
    end else begin
      if (ctrl_write) begin
        control_reg[7] <= w_data_reg[7];
        control_reg[5:0] <= w_data_reg[5:0];
      end
      if (do_write && aw_addr_reg[31:0] == {28'h0000000, ADCC_OFF_CONFIG}) begin
        config_reg <= {3'h0, config_merged[4:0]};
      end
    end
  end

  // Busy: a start rise wins; end of conversion clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_reg <= ADCC_CONTROL_RESET[ADCC_BIT_BUSY];
    end else if (start_rise) begin
      busy_reg <= 1'b1;
    end else if (conv_end) begin
      busy_reg <= 1'b0;
    end
  end

  assign start_rise = start_bit && !start_prev_reg;
  assign start_fall = !start_bit && start_prev_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_prev_reg <= 1'b0;
    end else begin
      start_prev_reg <= start_bit;
    end
  end

  // Conversion sequencer, sampling and converting steps counted in divided converter clock ticks
  always_ff @(posedge aclk) begin
    if (!aresetn || !cfg.power) begin
      state_reg <= ADCC_IDLE;
      phase_count_reg <= 5'h00;
    end else if (start_bit) begin
      state_reg <= ADCC_HELD;
      phase_count_reg <= 5'h00;
    end else begin
      case (state_reg)
        ADCC_IDLE: begin
          phase_count_reg <= 5'h00;
        end
        ADCC_HELD: begin
          state_reg <= ADCC_SAMPLE;
        end
        ADCC_SAMPLE: begin
          if (tick) begin
            if (phase_count_reg == ADCC_SAMPLE_CYCLES - 5'h01) begin
              state_reg <= ADCC_CONVERT;
              phase_count_reg <= 5'h00;
            end else begin
              phase_count_reg <= phase_count_reg + 5'h01;
            end
          end
        end
        ADCC_CONVERT: begin
          if (tick) begin
            if (phase_count_reg == ADCC_CONVERT_CYCLES - 5'h01) begin
              state_reg <= ADCC_IDLE;
              phase_count_reg <= 5'h00;
            end else begin
              phase_count_reg <= phase_count_reg + 5'h01;
            end
          end
        end
        default: begin
          state_reg <= ADCC_IDLE;
        end
      endcase
    end
  end

  assign conv_end = state_reg == ADCC_CONVERT && tick
                    && phase_count_reg == ADCC_CONVERT_CYCLES - 5'h01 && !start_bit && cfg.power;
  assign sar_clear = state_reg != ADCC_CONVERT;

  adcc_clkdiv u_clkdiv (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(state_reg == ADCC_SAMPLE || state_reg == ADCC_CONVERT),
    .divider_select(cfg.divider),
    .tick(tick)
  );

  adcc_sar u_sar (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(sar_clear),
    .tick(tick),
    .compare_in(compare_in),
    .trial(trial),
    .result(sar_result)
  );

  // Result bytes load with busy clearing; last bit folded in from the comparator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_low_byte_reg <= 8'h00;
      result_high_byte_reg <= 8'h00;
    end else if (conv_end) begin
      if (cfg.align) begin
        result_high_byte_reg <= {4'h0, sar_result[11:8]};
        result_low_byte_reg <= {sar_result[7:1], compare_in};
      end else begin
        result_high_byte_reg <= sar_result[11:4];
        result_low_byte_reg <= {sar_result[3:1], compare_in, 4'h0};
      end
    end
  end

  // Analog side controls, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_power_enable <= 1'b0;
      converter_reset <= 1'b0;
      external_reference_sel <= 1'b0;
      sample_hold <= 1'b0;
      dac_trial <= 12'h000;
      conv_done_irq <= 1'b0;
    end else begin
      converter_power_enable <= cfg.power;
      converter_reset <= start_bit;
      external_reference_sel <= cfg.reference == ADCC_REF_EXTERNAL;
      sample_hold <= state_reg == ADCC_SAMPLE;
      dac_trial <= trial;
      conv_done_irq <= conv_end;
    end
  end

  // One-hot routing; the routed pin drops its pull-high
  for (genvar i = 0; i < NUM_SOURCES; i++) begin : g_route
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        source_route[i] <= 1'b0;
        pin_pullup_disable[i] <= 1'b0;
      end else begin
        source_route[i] <= cfg.power && cfg.source == 4'(i);
        pin_pullup_disable[i] <= cfg.power && cfg.source == 4'(i);
      end
    end
  end

  // AXI read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ADCC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= ADCC_RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        if (s_axi_araddr[31:4] != 28'h0000000 || s_axi_araddr[1:0] != 2'h0) begin
          s_axi_rresp <= ADCC_RESP_SLVERR;
        end else begin
          case (s_axi_araddr[3:0])
            ADCC_OFF_RESULT_LOW: s_axi_rdata[7:0] <= result_low_byte_reg;
            ADCC_OFF_RESULT_HIGH: s_axi_rdata[7:0] <= result_high_byte_reg;
            ADCC_OFF_CONTROL: s_axi_rdata[7:0] <= {control_reg[7], busy_reg, control_reg[5:0]};
            ADCC_OFF_CONFIG: s_axi_rdata[7:0] <= {3'h0, config_reg[4:0]};
            default: s_axi_rresp <= ADCC_RESP_SLVERR;
          endcase
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  chk_busy_on_start: assert property (@(posedge aclk) disable iff (!aresetn)
    start_rise |=> busy_reg)
    else $error("busy not set by start");
  chk_busy_clear_end: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_end && !start_rise |=> !busy_reg && conv_done_irq)
    else $error("busy not cleared at end");
  chk_held_while_start: assert property (@(posedge aclk) disable iff (!aresetn)
    start_bit && cfg.power |=> state_reg == ADCC_HELD && converter_reset)
    else $error("converter not held while start high");
  chk_fall_begins: assert property (@(posedge aclk) disable iff (!aresetn)
    start_fall && cfg.power && state_reg == ADCC_HELD |=> state_reg == ADCC_SAMPLE)
    else $error("start fall did not begin sampling");
  chk_result_align0: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_end && !cfg.align |=> result_high_byte_reg == $past(sar_result[11:4])
                               && result_low_byte_reg[3:0] == 4'h0)
    else $error("left aligned result wrong");
  chk_result_align1: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_end && cfg.align |=> result_high_byte_reg[7:4] == 4'h0
                              && result_low_byte_reg[7:1] == $past(sar_result[7:1]))
    else $error("right aligned result wrong");
  chk_ref_select: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 external_reference_sel == ($past(config_reg[4:3]) == 2'h1))
    else $error("reference select wrong");
  chk_config_top_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    config_reg[7:5] == 3'h0)
    else $error("config upper bits nonzero");
  chk_route_onehot: assert property (@(posedge aclk) disable iff (!aresetn)
    $onehot0(source_route))
    else $error("more than one source routed");
  chk_results_with_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(result_high_byte_reg) |-> $fell(busy_reg) || $past(start_rise))
    else $error("result changed without busy clearing");
  chk_sample_len: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ADCC_SAMPLE && tick && phase_count_reg == 5'h03 && !start_bit && cfg.power
    |=> state_reg == ADCC_CONVERT)
    else $error("sampling length wrong");

  cov_conversion: cover property (@(posedge aclk) disable iff (!aresetn) conv_end);
  cov_align1_done: cover property (@(posedge aclk) disable iff (!aresetn) conv_end && cfg.align);
  cov_restart: cover property (@(posedge aclk) disable iff (!aresetn)
    start_rise && state_reg == ADCC_CONVERT);
endmodule // adcc_top

/* adcc_pkg.sv */
package adcc_pkg;
  localparam logic [3:0] ADCC_OFF_RESULT_LOW = 4'h0;
  localparam logic [3:0] ADCC_OFF_RESULT_HIGH = 4'h4;
  localparam logic [3:0] ADCC_OFF_CONTROL = 4'h8;
  localparam logic [3:0] ADCC_OFF_CONFIG = 4'hC;
  localparam logic [7:0] ADCC_CONTROL_RESET = 8'h40;
  localparam logic [7:0] ADCC_CONFIG_RESET = 8'h00;
  localparam int ADCC_BIT_START = 7;
  localparam int ADCC_BIT_BUSY = 6;
  localparam int ADCC_BIT_POWER = 5;
  localparam int ADCC_BIT_ALIGN = 4;
  localparam int ADCC_SRC_LSB = 0;
  localparam int ADCC_REF_LSB = 3;
  localparam int ADCC_DIV_LSB = 0;
  localparam logic [1:0] ADCC_REF_EXTERNAL = 2'h1;
  localparam logic [4:0] ADCC_SAMPLE_CYCLES = 5'h04;
  localparam logic [4:0] ADCC_CONVERT_CYCLES = 5'h0C;
  localparam logic [1:0] ADCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ADCC_RESP_SLVERR = 2'h2;

  typedef enum {ADCC_IDLE, ADCC_HELD, ADCC_SAMPLE, ADCC_CONVERT} adcc_state_type;

  typedef struct packed {
    logic power;
    logic align;
    logic [3:0] source;
    logic [1:0] reference;
    logic [2:0] divider;
  } adcc_cfg_type;
endpackage

/* adcc_clkdiv.sv */
`timescale 1ns/1ps
module adcc_clkdiv
  import adcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [2:0] divider_select,
  output logic tick
);
  logic [6:0] count_reg;
  logic [6:0] limit;

  // Code n divides by 2**n
  assign limit = 7'((8'h01 << divider_select) - 8'h01);

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count_reg <= 7'h00;
      tick <= 1'b0;
    end else if (count_reg >= limit) begin
      count_reg <= 7'h00;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 7'h01;
      tick <= 1'b0;
    end
  end
endmodule // adcc_clkdiv

/* adcc_sar.sv */
`timescale 1ns/1ps
module adcc_sar
  import adcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic tick,
  input wire logic compare_in,
  output logic [11:0] trial,
  output logic [11:0] result
);
  logic [11:0] bit_reg;

  // Successive approximation: keep each trial bit the comparator accepts
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      bit_reg <= 12'h800;
      result <= 12'h000;
    end else if (tick && bit_reg != 12'h000) begin
      if (compare_in) begin
        result <= result | bit_reg;
      end
      bit_reg <= bit_reg >> 1;
    end
  end

  // Trial as it stands after this edge, so the registered copy at the converter
  // is current even when a tick falls on every clock
  always_comb begin
    if (!aresetn || clear) begin
      trial = 12'h800;
    end else if (tick && bit_reg != 12'h000) begin
      trial = (compare_in ? (result | bit_reg) : result) | (bit_reg >> 1);
    end else begin
      trial = result | bit_reg;
    end
  end
endmodule // adcc_sar

/* adcc_analog_model.sv */
`timescale 1ns/1ps
module adcc_analog_model
  import adcc_pkg::*;
(
  input wire logic aclk,
  input wire logic [11:0] level,
  input wire logic [11:0] dac_trial,
  input wire logic power,
  input wire logic sample_hold,
  output logic compare_in
);
  logic [11:0] held_reg;
  logic noise_reg = 1'b0;
  // Track the input only in the sampling window, then hold it for the bit trials
  always_ff @(posedge aclk) begin
    if (sample_hold) held_reg <= level;
  end
  always_ff @(posedge aclk) begin
    noise_reg <= ~noise_reg;
  end
  // An unpowered comparator gives no valid answer, so the line wanders
  assign compare_in = power ? (held_reg >= dac_trial) : noise_reg;
endmodule // adcc_analog_model

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import adcc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, r;
  logic compare_in, sample_hold, power_en, conv_reset, ext_ref, irq;
  logic [11:0] dac_trial, vin = 12'h000;
  logic [15:0] route, pullup_off;
  int error_cnt = 0, check_count = 0, cyc = 0, t_start = 0, t_irq = 0, sh_cnt = 0, irq_cnt = 0;
  integer seed = 32'h9217C7C7;
  logic sh_prev = 1'b0;

  always #12.5 aclk = ~aclk;

  adcc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .compare_in(compare_in), .dac_trial(dac_trial), .sample_hold(sample_hold),
    .converter_power_enable(power_en), .converter_reset(conv_reset),
    .external_reference_sel(ext_ref), .source_route(route), .pin_pullup_disable(pullup_off),
    .conv_done_irq(irq));

  adcc_analog_model core (.aclk(aclk), .level(vin), .dac_trial(dac_trial), .power(power_en),
    .sample_hold(sample_hold), .compare_in(compare_in));

  // Timestamps of the sampling window and the completion pulse
  always @(posedge aclk) begin
    cyc++;
    if (sample_hold === 1'b1) sh_cnt++;
    if (sample_hold === 1'b1 && !sh_prev) t_start = cyc;
    if (irq === 1'b1) begin
      t_irq = cyc;
      irq_cnt++;
    end
    sh_prev = (sample_hold === 1'b1);
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  function automatic logic [31:0] ctl(input bit st, input bit pw, input bit al,
                                      input logic [3:0] s);
    return (32'(st) << ADCC_BIT_START) | (32'(pw) << ADCC_BIT_POWER)
           | (32'(al) << ADCC_BIT_ALIGN) | 32'(s);
  endfunction

  function automatic logic [7:0] hi_byte(input logic [11:0] v, input bit al);
    return al ? {4'h0, v[11:8]} : v[11:4];
  endfunction

  function automatic logic [7:0] lo_byte(input logic [11:0] v, input bit al);
    return al ? v[7:0] : {v[3:0], 4'h0};
  endfunction

  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] v;
    logic [3:0] src;
    logic [1:0] rsel;
    bit al;
    int n, irq0, len;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_read({28'h0, ADCC_OFF_CONTROL}, v, r);
    check("control reset", v, 32'(ADCC_CONTROL_RESET));
    axi_read({28'h0, ADCC_OFF_CONFIG}, v, r);
    check("config reset", v, 32'(ADCC_CONFIG_RESET));
    axi_write({28'h0, ADCC_OFF_CONFIG}, 32'hFF, r);
    axi_read({28'h0, ADCC_OFF_CONFIG}, v, r);
    check("config upper zero", v, 32'h1F);
    // A write with byte lane 0 off must leave the register alone
    wstrb <= 4'h0;
    axi_write({28'h0, ADCC_OFF_CONFIG}, 32'h00, r);
    wstrb <= 4'hF;
    check("strobe off resp", {30'h0, r}, {30'h0, ADCC_RESP_OKAY});
    axi_read({28'h0, ADCC_OFF_CONFIG}, v, r);
    check("strobe off keeps", v, 32'h1F);
    axi_read(32'h10, v, r);
    check("unmapped read resp", {30'h0, r}, {30'h0, ADCC_RESP_SLVERR});
    check("unmapped read data", v, 32'h0);
    axi_write(32'h10, 32'hFF, r);
    check("unmapped write resp", {30'h0, r}, {30'h0, ADCC_RESP_SLVERR});
    // Dividers below 32 break the period limit at 40 MHz; the model is ideal, so results hold
    for (int d = 0; d < 8; d++) begin
      vin <= (d == 0) ? 12'h000 : (d == 7) ? 12'hFFF : 12'($random(seed));
      src = 4'($random(seed));
      rsel = 2'(d);
      al = d[0];
      axi_write({28'h0, ADCC_OFF_CONFIG}, 32'({rsel, 3'(d)}), r);
      axi_write({28'h0, ADCC_OFF_CONTROL}, ctl(0, 1, al, src), r);
      repeat (20) @(posedge aclk);
      check("route", {16'h0, route}, 32'(16'h1 << src));
      check("pullup off", {16'h0, pullup_off}, 32'(16'h1 << src));
      check("power", {31'h0, power_en}, 32'h1);
      check("ext ref", {31'h0, ext_ref}, {31'h0, rsel == ADCC_REF_EXTERNAL});
      axi_write({28'h0, ADCC_OFF_CONTROL}, ctl(1, 1, al, src), r);
      axi_read({28'h0, ADCC_OFF_CONTROL}, v, r);
      check("busy on start", {31'h0, v[ADCC_BIT_BUSY]}, 32'h1);
      check("held reset", {31'h0, conv_reset}, 32'h1);
      sh_cnt = 0;
      irq0 = irq_cnt;
      axi_write({28'h0, ADCC_OFF_CONTROL}, ctl(0, 1, al, src), r);
      n = 0;
      while (irq_cnt == irq0 && n < 5000) begin
        @(posedge aclk);
        n++;
      end
      len = t_irq - t_start;
      check("sample span", {31'h0, sh_cnt >= (4 << d) - 1 && sh_cnt <= (4 << d) + 1}, 1);
      check("conv span", {31'h0, len >= (16 << d) - 1 && len <= (16 << d) + 2}, 1);
      n = 0;
      do begin
        axi_read({28'h0, ADCC_OFF_CONTROL}, v, r);
        n++;
      end while (v[ADCC_BIT_BUSY] !== 1'b0 && n < 50);
      check("busy cleared", {31'h0, v[ADCC_BIT_BUSY]}, 32'h0);
      check("one irq", irq_cnt - irq0, 1);
      axi_read({28'h0, ADCC_OFF_RESULT_HIGH}, v, r);
      check("result high", v, {24'h0, hi_byte(vin, al)});
      axi_read({28'h0, ADCC_OFF_RESULT_LOW}, v, r);
      check("result low", v, {24'h0, lo_byte(vin, al)});
    end
    // Power down when idle
    axi_write({28'h0, ADCC_OFF_CONTROL}, ctl(0, 0, 0, 4'h3), r);
    repeat (3) @(posedge aclk);
    check("power off", {31'h0, power_en}, 32'h0);
    check("route off", {16'h0, route}, 32'h0);
    tally_and_finish();
  end
endmodule // tb_top
